// ### dprs_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef DPRS_REGS_SVH
`define DPRS_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DPRS_ADDR_HPCFG 8'h00
`define DPRS_ADDR_PINFUNC 8'h04
`define DPRS_ADDR_SLOTCTL 8'h08
`define DPRS_ADDR_BRIDGECTL 8'h0c
`define DPRS_ADDR_SWITCHCTL 8'h10
`define DPRS_ADDR_RSTSTAT 8'h14
`define DPRS_ADDR_PGSTAT 8'h18
`define DPRS_ADDR_SBRSTAT 8'h1c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define DPRS_HPCFG_MODE_LSB 0
`define DPRS_HPCFG_MODE_MSB 1
`define DPRS_HPCFG_P2R_LSB 8
`define DPRS_HPCFG_P2R_MSB 15
`define DPRS_HPCFG_R2P_LSB 16
`define DPRS_HPCFG_R2P_MSB 23
`define DPRS_PORT_LSB 1
`define DPRS_PORT_MSB 15
`define DPRS_SWITCHCTL_SBR_BIT 0
`define DPRS_HPCFG_RESET 32'h00000000
`define DPRS_PINFUNC_RESET 15'h0000
`define DPRS_SLOTCTL_RESET 15'h7fff

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DPRS_CLK_MHZ 10
`define DPRS_MIN_PULSE_US 200
`define DPRS_MIN_PULSE_CYC (`DPRS_MIN_PULSE_US * `DPRS_CLK_MHZ)
`define DPRS_DELAY_UNIT_US 10
`define DPRS_DELAY_UNIT_CYC (`DPRS_DELAY_UNIT_US * `DPRS_CLK_MHZ)

`endif

// ### dprs_pkg.sv
// Types shared by the downstream port reset sequencer.
package dprs_pkg;

  // --------------------------------------------------------------------
  // Reset output modes
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    DPRS_MODE_PWREN = 2'h0,
    DPRS_MODE_PWRGOOD = 2'h1,
    DPRS_MODE_HOTRST = 2'h2,
    DPRS_MODE_RSVD = 2'h3
  } dprs_mode_t;

  // --------------------------------------------------------------------
  // Per-port state machines, Gray coded along the usual path
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    DPRS_SBR_IDLE = 2'h0,
    DPRS_SBR_HOT = 2'h1,
    DPRS_SBR_FLUSH = 2'h3,
    DPRS_SBR_HOLD = 2'h2
  } dprs_sbr_state_t;

  typedef enum logic [1:0] {
    DPRS_PWR_OFF = 2'h0,
    DPRS_PWR_RAMP = 2'h1,
    DPRS_PWR_ON = 2'h3,
    DPRS_PWR_DOWN = 2'h2
  } dprs_pwr_state_t;

endpackage

// ### dprs_sequencer.sv
// Reset sequencer for the downstream ports of a switch.
`include "dprs_regs.svh"

module dprs_sequencer
  import dprs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic [15:1] linkUp,
  input wire logic [15:1] flushDone,
  input wire logic [15:1] hotResetIn,
  input wire logic [15:1] portPowerGoodInN,
  output logic [15:1] tsHotResetTx,
  output logic [15:1] discardQueued,
  output logic [15:1] urSecondary,
  output logic [15:1] portResetOutN,
  output logic [15:1] portResetOutOeN,
  output logic [15:1] portPowerEnableOut
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [15:0] delayCycles(input logic [7:0] field);
    logic [31:0] prod;
    prod = 32'(field) * 32'(`DPRS_DELAY_UNIT_CYC);
    return prod[15:0];
  endfunction

  function automatic logic regHit(input logic [7:0] addr,
                                  input logic [7:0] offset);
    return addr == offset;
  endfunction

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [31:0] hpcfg_reg;
  logic [15:1] pinFunc_reg;
  logic [15:1] slotPcc_reg;
  logic [15:1] bridgeSbr_reg;
  logic switchSbr_reg;
  logic [31:0] rdData_reg;
  logic [15:1] pgSync1_reg;
  logic [15:1] pgSync2_reg;
  logic [15:1] rstAsserted_reg;
  logic [15:1] rstAsserted_next;
  logic [15:1] tsHot_reg;
  logic [15:1] discard_reg;
  logic [15:1] ur_reg;
  logic [15:1] pep_reg;
  logic [15:1] sbrStart;
  logic [15:1] pgood;
  logic [15:1] rstWanted;
  dprs_mode_t mode;
  logic [15:0] p2rCycles;
  logic [15:0] r2pCycles;
  dprs_sbr_state_t sbrState_reg [1:15];
  dprs_sbr_state_t sbrState_next [1:15];
  dprs_pwr_state_t pwrState_reg [1:15];
  dprs_pwr_state_t pwrState_next [1:15];
  logic [15:0] delayCnt_reg [1:15];
  logic [15:0] delayCnt_next [1:15];
  logic [11:0] pulseCnt_reg [1:15];

  logic wrHpcfg;
  logic wrPinFunc;
  logic wrSlot;
  logic wrBridge;
  logic wrSwitch;

  assign wrHpcfg = regWrStb && regHit(regAddr, `DPRS_ADDR_HPCFG);
  assign wrPinFunc = regWrStb && regHit(regAddr, `DPRS_ADDR_PINFUNC);
  assign wrSlot = regWrStb && regHit(regAddr, `DPRS_ADDR_SLOTCTL);
  assign wrBridge = regWrStb && regHit(regAddr, `DPRS_ADDR_BRIDGECTL);
  assign wrSwitch = regWrStb && regHit(regAddr, `DPRS_ADDR_SWITCHCTL);

  assign mode = dprs_mode_t'(
    hpcfg_reg[`DPRS_HPCFG_MODE_MSB:`DPRS_HPCFG_MODE_LSB]);
  assign p2rCycles =
    delayCycles(hpcfg_reg[`DPRS_HPCFG_P2R_MSB:`DPRS_HPCFG_P2R_LSB]);
  assign r2pCycles =
    delayCycles(hpcfg_reg[`DPRS_HPCFG_R2P_MSB:`DPRS_HPCFG_R2P_LSB]);

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hpcfg_reg <= `DPRS_HPCFG_RESET;
      pinFunc_reg <= `DPRS_PINFUNC_RESET;
      slotPcc_reg <= `DPRS_SLOTCTL_RESET;
      bridgeSbr_reg <= 15'h0000;
      switchSbr_reg <= 1'b0;
    end else if (clkEn) begin
      if (wrHpcfg) begin
        hpcfg_reg <= regWrData & 32'h00ffff03;
      end
      if (wrPinFunc) begin
        pinFunc_reg <= regWrData[`DPRS_PORT_MSB:`DPRS_PORT_LSB];
      end
      if (wrSlot) begin
        slotPcc_reg <= regWrData[`DPRS_PORT_MSB:`DPRS_PORT_LSB];
      end
      if (wrBridge) begin
        bridgeSbr_reg <= regWrData[`DPRS_PORT_MSB:`DPRS_PORT_LSB];
      end
      if (wrSwitch) begin
        switchSbr_reg <= regWrData[`DPRS_SWITCHCTL_SBR_BIT];
      end
    end
  end

  // A start is taken only from an idle port; repeated writes of one while
  // the sequence runs do not restart it.
  always_comb begin
    for (int p = 1; p <= 15; p++) begin
      sbrStart[p] = wrBridge && regWrData[p] &&
                    (sbrState_reg[p] == DPRS_SBR_IDLE);
    end
  end

  // --------------------------------------------------------------------
  // Register read port, answered one cycle after the strobe
  // --------------------------------------------------------------------
  // Reads never depend on reset sequencing, so management access stays
  // usable throughout a port reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData_reg <= 32'h00000000;
    end else if (clkEn) begin
      rdData_reg <= 32'h00000000;
      if (regRdStb) begin
        if (regHit(regAddr, `DPRS_ADDR_HPCFG)) begin
          rdData_reg <= hpcfg_reg;
        end else if (regHit(regAddr, `DPRS_ADDR_PINFUNC)) begin
          rdData_reg <= {16'h0000, pinFunc_reg, 1'b0};
        end else if (regHit(regAddr, `DPRS_ADDR_SLOTCTL)) begin
          rdData_reg <= {16'h0000, slotPcc_reg, 1'b0};
        end else if (regHit(regAddr, `DPRS_ADDR_BRIDGECTL)) begin
          rdData_reg <= {16'h0000, bridgeSbr_reg, 1'b0};
        end else if (regHit(regAddr, `DPRS_ADDR_SWITCHCTL)) begin
          rdData_reg <= {31'h00000000, switchSbr_reg};
        end else if (regHit(regAddr, `DPRS_ADDR_RSTSTAT)) begin
          rdData_reg <= {16'h0000, rstAsserted_reg, 1'b0};
        end else if (regHit(regAddr, `DPRS_ADDR_PGSTAT)) begin
          rdData_reg <= {16'h0000, pgood, 1'b0};
        end else if (regHit(regAddr, `DPRS_ADDR_SBRSTAT)) begin
          rdData_reg <= {16'h0000, ur_reg, 1'b0};
        end else begin
          rdData_reg <= 32'h00000000;
        end
      end
    end
  end

  assign regRdData = rdData_reg;

  // --------------------------------------------------------------------
  // Power good synchroniser
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pgSync1_reg <= 15'h7fff;
      pgSync2_reg <= 15'h7fff;
    end else if (clkEn) begin
      pgSync1_reg <= portPowerGoodInN;
      pgSync2_reg <= pgSync1_reg;
    end
  end

  assign pgood = ~pgSync2_reg;

  // --------------------------------------------------------------------
  // Secondary bus reset sequence, one independent machine per port
  // --------------------------------------------------------------------
  // Each port has its own state, so a reset of one port never touches
  // another port or the upstream port.
  always_comb begin
    for (int p = 1; p <= 15; p++) begin
      sbrState_next[p] = sbrState_reg[p];
      case (sbrState_reg[p])
        DPRS_SBR_IDLE: begin
          if (sbrStart[p]) begin
            sbrState_next[p] = DPRS_SBR_HOT;
          end
        end
        DPRS_SBR_HOT: begin
          sbrState_next[p] = DPRS_SBR_FLUSH;
        end
        DPRS_SBR_FLUSH: begin
          if (flushDone[p]) begin
            sbrState_next[p] = DPRS_SBR_HOLD;
          end
        end
        DPRS_SBR_HOLD: begin
          if (!switchSbr_reg) begin
            sbrState_next[p] = DPRS_SBR_IDLE;
          end
        end
        default: begin
          sbrState_next[p] = DPRS_SBR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int p = 1; p <= 15; p++) begin
        sbrState_reg[p] <= DPRS_SBR_IDLE;
      end
    end else if (clkEn) begin
      for (int p = 1; p <= 15; p++) begin
        sbrState_reg[p] <= sbrState_next[p];
      end
    end
  end

  // Configuration requests are not routed through this block, so type 0
  // accesses to the bridge itself carry on during the reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tsHot_reg <= 15'h0000;
      discard_reg <= 15'h0000;
      ur_reg <= 15'h0000;
    end else if (clkEn) begin
      for (int p = 1; p <= 15; p++) begin
        tsHot_reg[p] <= (sbrState_next[p] != DPRS_SBR_IDLE) &&
                        linkUp[p];
        discard_reg[p] <= sbrState_next[p] == DPRS_SBR_FLUSH;
        ur_reg[p] <= sbrState_next[p] != DPRS_SBR_IDLE;
      end
    end
  end

  assign tsHotResetTx = tsHot_reg;
  assign discardQueued = discard_reg;
  assign urSecondary = ur_reg;

  // --------------------------------------------------------------------
  // Slot power sequence, one machine per port
  // --------------------------------------------------------------------
  always_comb begin
    for (int p = 1; p <= 15; p++) begin
      pwrState_next[p] = pwrState_reg[p];
      delayCnt_next[p] = delayCnt_reg[p];
      case (pwrState_reg[p])
        DPRS_PWR_OFF: begin
          delayCnt_next[p] = 16'h0000;
          if (!slotPcc_reg[p]) begin
            pwrState_next[p] = DPRS_PWR_RAMP;
          end
        end
        DPRS_PWR_RAMP: begin
          if (slotPcc_reg[p]) begin
            pwrState_next[p] = DPRS_PWR_DOWN;
            delayCnt_next[p] = 16'h0000;
          end else if (mode == DPRS_MODE_PWRGOOD && !pgood[p]) begin
            delayCnt_next[p] = 16'h0000;
          end else if (delayCnt_reg[p] >= p2rCycles) begin
            pwrState_next[p] = DPRS_PWR_ON;
          end else begin
            delayCnt_next[p] = delayCnt_reg[p] + 16'h0001;
          end
        end
        DPRS_PWR_ON: begin
          delayCnt_next[p] = 16'h0000;
          if (slotPcc_reg[p]) begin
            pwrState_next[p] = DPRS_PWR_DOWN;
          end else if (mode == DPRS_MODE_PWRGOOD && !pgood[p]) begin
            pwrState_next[p] = DPRS_PWR_RAMP;
          end
        end
        DPRS_PWR_DOWN: begin
          if (delayCnt_reg[p] >= r2pCycles) begin
            pwrState_next[p] = DPRS_PWR_OFF;
            delayCnt_next[p] = 16'h0000;
          end else begin
            delayCnt_next[p] = delayCnt_reg[p] + 16'h0001;
          end
        end
        default: begin
          pwrState_next[p] = DPRS_PWR_OFF;
          delayCnt_next[p] = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int p = 1; p <= 15; p++) begin
        pwrState_reg[p] <= DPRS_PWR_OFF;
        delayCnt_reg[p] <= 16'h0000;
      end
    end else if (clkEn) begin
      for (int p = 1; p <= 15; p++) begin
        pwrState_reg[p] <= pwrState_next[p];
        delayCnt_reg[p] <= delayCnt_next[p];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pep_reg <= 15'h0000;
    end else if (clkEn) begin
      for (int p = 1; p <= 15; p++) begin
        pep_reg[p] <= pwrState_next[p] != DPRS_PWR_OFF;
      end
    end
  end

  assign portPowerEnableOut = pep_reg;

  // --------------------------------------------------------------------
  // Port reset outputs
  // --------------------------------------------------------------------
  // The fault term looks at the live power good level so a loss of power
  // asserts reset on the next edge instead of waiting for the state change.
  // The synchroniser still adds two cycles; a faster response has to be
  // built outside.
  always_comb begin
    for (int p = 1; p <= 15; p++) begin
      if (mode == DPRS_MODE_HOTRST) begin
        rstWanted[p] = (sbrState_reg[p] != DPRS_SBR_IDLE) ||
                       hotResetIn[p];
      end else begin
        rstWanted[p] = (pwrState_reg[p] != DPRS_PWR_ON) ||
                       slotPcc_reg[p] ||
                       (mode == DPRS_MODE_PWRGOOD && !pgood[p]);
      end
      rstAsserted_next[p] = rstWanted[p] ||
        (rstAsserted_reg[p] &&
         pulseCnt_reg[p] < 12'(`DPRS_MIN_PULSE_CYC));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rstAsserted_reg <= 15'h7fff;
      for (int p = 1; p <= 15; p++) begin
        pulseCnt_reg[p] <= 12'h000;
      end
    end else if (clkEn) begin
      rstAsserted_reg <= rstAsserted_next;
      for (int p = 1; p <= 15; p++) begin
        if (!rstAsserted_reg[p]) begin
          pulseCnt_reg[p] <= 12'h000;
        end else if (pulseCnt_reg[p] < 12'(`DPRS_MIN_PULSE_CYC)) begin
          pulseCnt_reg[p] <= pulseCnt_reg[p] + 12'h001;
        end
      end
    end
  end

  // Undriven pins rely on board pull-downs to read as reset.
  assign portResetOutN = ~rstAsserted_reg;
  assign portResetOutOeN = ~pinFunc_reg;

endmodule // dprs_sequencer

// ### dprs_slot_model.sv
// Hot-plug slot model: power switch, power good and reset pin wiring.
module dprs_slot_model #(
  parameter int RAMP = 300
) (
  input wire logic ref_clk,
  input wire logic [15:1] powerEnable,
  input wire logic [15:1] fault,
  input wire logic [15:1] resetOutN,
  input wire logic [15:1] resetOeN,
  output logic [15:1] powerGoodN,
  output logic [15:1] resetPin
);
  // ------------------------------------------------------------------
  // Supply ramp and pin resolution
  // ------------------------------------------------------------------
  int rampCnt [15:1] = '{default: 0};

  // Power good is lost on the first edge that sees the enable low; no grace period.
  always @(posedge ref_clk) begin
    for (int i = 1; i <= 15; i++) begin
      if (!powerEnable[i]) begin
        rampCnt[i] <= 0;
      end else if (rampCnt[i] < RAMP) begin
        rampCnt[i] <= rampCnt[i] + 1;
      end
    end
  end

  always_comb begin
    for (int i = 1; i <= 15; i++) begin
      powerGoodN[i] = !(rampCnt[i] >= RAMP && !fault[i]);
      resetPin[i] = resetOeN[i] ? 1'b0 : resetOutN[i];
    end
  end
endmodule // dprs_slot_model

// ### dprs_sequencer_monitor.sv
// Port-level assertions for the downstream port reset sequencer.
`include "dprs_regs.svh"
module dprs_sequencer_monitor
  import dprs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic [15:1] linkUp,
  input wire logic [15:1] portPowerGoodInN,
  input wire logic [15:1] tsHotResetTx,
  input wire logic [15:1] discardQueued,
  input wire logic [15:1] urSecondary,
  input wire logic [15:1] portResetOutN,
  input wire logic [15:1] portResetOutOeN,
  input wire logic [15:1] portPowerEnableOut
);
  // ------------------------------------------------------------------
  // Shadow state
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  dprs_mode_t modeReg;
  logic [15:1] slotReg;
  logic swReg;
  logic [11:0] lowCnt [15:1];

  sequence s_wr(logic [7:0] a);
    regWrStb && clkEn && regAddr == a;
  endsequence

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      modeReg <= DPRS_MODE_PWREN;
      swReg <= 1'b0;
    end else if (regWrStb && clkEn && regAddr == `DPRS_ADDR_HPCFG) begin
      modeReg <= dprs_mode_t'(regWrData[1:0]);
    end else if (regWrStb && clkEn && regAddr == `DPRS_ADDR_SWITCHCTL) begin
      swReg <= regWrData[0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slotReg <= `DPRS_SLOTCTL_RESET;
    end else if (regWrStb && clkEn && regAddr == `DPRS_ADDR_SLOTCTL) begin
      slotReg <= regWrData[15:1];
    end
  end

  // Saturates, so very long pulses still pass the width check.
  always_ff @(posedge ref_clk) begin
    for (int i = 1; i <= 15; i++) begin
      if (rst || portResetOutN[i]) begin
        lowCnt[i] <= 12'h000;
      end else if (lowCnt[i] != 12'hfff) begin
        lowCnt[i] <= lowCnt[i] + 12'h001;
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_rd_idle_zero: assert property (!regRdStb |=> regRdData == 32'h0)
    else $error("read data not zero outside read cycle");
  a_oe_func_sel: assert property (s_wr(`DPRS_ADDR_PINFUNC) |=> ##1
    portResetOutOeN == ~$past(regWrData[15:1], 2))
    else $error("pin enable does not follow function select");
  a_sbr_start_port: assert property (s_wr(`DPRS_ADDR_BRIDGECTL) |=> ##1
    ((urSecondary & $past(regWrData[15:1], 2) & ~$past(urSecondary, 2))
    == ($past(regWrData[15:1], 2) & ~$past(urSecondary, 2))))
    else $error("secondary reset did not start");
  a_ts_link_up: assert property (
    (tsHotResetTx & ~(urSecondary & $past(linkUp))) == 15'h0000)
    else $error("hot reset sets sent without reset or link");
  a_discard_in_sbr: assert property (
    (discardQueued & ~urSecondary) == 15'h0000)
    else $error("discard outside secondary reset");
  a_sbr_hold_sw: assert property (
    |($past(urSecondary) & ~urSecondary) |-> !$past(swReg))
    else $error("secondary reset ended with switch bit set");

  for (genvar i = 1; i <= 15; i++) begin : g_port
    a_pulse_min_width: assert property (
      $rose(portResetOutN[i]) |-> lowCnt[i] >= 12'h7c6)
      else $error("reset pulse too short");
    a_fault_reset_now: assert property (modeReg == DPRS_MODE_PWRGOOD &&
      portResetOutN[i] && $rose(portPowerGoodInN[i]) |-> ##[1:4]
      !portResetOutN[i])
      else $error("power fault did not assert reset");
    a_pep_edge_rst: assert property (modeReg != DPRS_MODE_HOTRST &&
      ($rose(portPowerEnableOut[i]) || $fell(portPowerEnableOut[i]))
      |-> !portResetOutN[i])
      else $error("power enable moved while reset negated");
    a_off_in_reset: assert property (
      (!portPowerEnableOut[i] && modeReg != DPRS_MODE_HOTRST) [*3]
      |-> !portResetOutN[i])
      else $error("reset negated while slot power off");
    a_pep_on_write: assert property (s_wr(`DPRS_ADDR_SLOTCTL) ##0
      (slotReg[i] && !regWrData[i]) |=> ##[0:1] portPowerEnableOut[i])
      else $error("power enable not raised");
  end
endmodule // dprs_sequencer_monitor

// ### dprs_sequencer_bench.sv
// Self-checking bench for the downstream port reset sequencer.
`include "dprs_regs.svh"
module dprs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------------
  // Signals, instances and helpers
  // ------------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [31:0] regRdData;
  logic [15:1] linkUp = 15'h0008;
  logic [15:1] flushDone = 15'h0000;
  logic [15:1] hotResetIn = 15'h0000;
  logic [15:1] fault = 15'h0000;
  logic [15:1] pgN, ts, disc, ur, rstN, oeN, pep, pin;
  int n_fail = 0;
  int compares = 0;
  int n, t;

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  dprs_sequencer dut_u (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData(regRdData), .linkUp(linkUp),
    .flushDone(flushDone), .hotResetIn(hotResetIn),
    .portPowerGoodInN(pgN), .tsHotResetTx(ts), .discardQueued(disc),
    .urSecondary(ur), .portResetOutN(rstN), .portResetOutOeN(oeN),
    .portPowerEnableOut(pep));

  dprs_slot_model #(.RAMP(300)) slot_u (.ref_clk(ref_clk),
    .powerEnable(pep), .fault(fault), .resetOutN(rstN), .resetOeN(oeN),
    .powerGoodN(pgN), .resetPin(pin));

  function automatic logic inr(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 chk(what, exp, regRdData);
  endtask

  task cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask

  task wait_rn(input int p, input logic lvl, input int maxc, output int k);
    k = 0;
    while (k < maxc && rstN[p] !== lvl) begin
      @(posedge ref_clk);
      #1 k++;
    end
  endtask

  task finish_test;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task test_reset;
    #1 chk("pin enable", 32'h7fff, oeN);
    chk("pin level", 32'h0, pin);
    chk("power enable", 32'h0, pep);
    rd(`DPRS_ADDR_HPCFG, `DPRS_HPCFG_RESET, "hpcfg");
    rd(`DPRS_ADDR_PINFUNC, 32'h0, "pinfunc");
    rd(`DPRS_ADDR_SLOTCTL, 32'hfffe, "slotctl");
    rd(`DPRS_ADDR_RSTSTAT, 32'hfffe, "rststat");
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0, "unmapped");
    cyc(2100);
    $display("test_reset done");
  endtask

  task test_pin;
    wr(`DPRS_ADDR_PINFUNC, 32'h2);
    cyc(2);
    chk("pin enable", 32'h7ffe, oeN);
    rd(`DPRS_ADDR_PINFUNC, 32'h2, "pinfunc");
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wr(`DPRS_ADDR_PINFUNC, 32'h6);
    cyc(2);
    chk("frozen pin enable", 32'h7ffe, oeN);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    cyc(1);
    $display("test_pin done");
  endtask

  // Pulse is re-armed at once so the minimum width, not the delay, rules.
  task test_pwren;
    wr(`DPRS_ADDR_HPCFG, 32'h00010100);
    wr(`DPRS_ADDR_SLOTCTL, 32'hfffc);
    cyc(2);
    chk("enable first", 32'h1, {pep[1], rstN[1]} == 2'b10);
    wait_rn(1, 1'b1, 200, n);
    chk("p2r delay", 32'h1, inr(n, 95, 110));
    cyc(50);
    chk("pin negated", 32'h1, pin[1]);
    rd(`DPRS_ADDR_RSTSTAT, 32'hfffc, "rststat");
    wr(`DPRS_ADDR_SLOTCTL, 32'hfffe);
    wait_rn(1, 1'b0, 5, n);
    chk("reset first", 32'h1, inr(n, 0, 3) && pep[1] === 1'b1);
    t = 0;
    while (t < 200 && pep[1] !== 1'b0) begin
      cyc(1);
      t++;
    end
    chk("r2p delay", 32'h1, inr(t, 95, 110));
    wr(`DPRS_ADDR_SLOTCTL, 32'hfffc);
    wait_rn(1, 1'b1, 2500, n);
    chk("min pulse", 32'h1, inr(n + t + 2, 1995, 2015));
    $display("test_pwren done");
  endtask

  task test_pwrgood;
    wr(`DPRS_ADDR_HPCFG, 32'h00010101);
    wr(`DPRS_ADDR_SLOTCTL, 32'hfff8);
    wait_rn(2, 1'b1, 700, n);
    chk("pg delay", 32'h1, inr(n, 400, 415));
    rd(`DPRS_ADDR_PGSTAT, 32'h6, "pgstat");
    @(posedge ref_clk);
    fault <= 15'h0002;
    wait_rn(2, 1'b0, 8, n);
    chk("fault reset", 32'h1, inr(n, 1, 5));
    fault <= 15'h0000;
    $display("test_pwrgood done");
  endtask

  task test_hotrst;
    wr(`DPRS_ADDR_HPCFG, 32'h00010102);
    wait_rn(3, 1'b1, 10, n);
    chk("hot idle", 32'h1, inr(n, 0, 5));
    @(posedge ref_clk);
    hotResetIn <= 15'h0004;
    wait_rn(3, 1'b0, 5, n);
    chk("hot assert", 32'h1, inr(n, 0, 3));
    cyc(10);
    hotResetIn <= 15'h0000;
    wait_rn(3, 1'b1, 2500, n);
    chk("hot pulse", 32'h1, inr(n + 10, 1985, 2015));
    wr(`DPRS_ADDR_HPCFG, 32'h00010103);
    wait_rn(3, 1'b0, 5, n);
    chk("mode three", 32'h1, inr(n, 0, 3));
    $display("test_hotrst done");
  endtask

  task test_sbr;
    wr(`DPRS_ADDR_SWITCHCTL, 32'h1);
    wr(`DPRS_ADDR_BRIDGECTL, 32'h30);
    cyc(2);
    chk("ur", 32'h0018, ur);
    chk("ts", 32'h0008, ts);
    chk("discard", 32'h0018, disc);
    rd(`DPRS_ADDR_SBRSTAT, 32'h30, "sbrstat");
    rd(`DPRS_ADDR_HPCFG, 32'h00010103, "hpcfg");
    @(posedge ref_clk);
    flushDone <= 15'h0018;
    cyc(3);
    chk("flushed", 32'h0, disc);
    cyc(20);
    chk("held", 32'h0018, ur);
    wr(`DPRS_ADDR_SWITCHCTL, 32'h0);
    cyc(3);
    chk("released", 32'h0, {ur, ts});
    flushDone <= 15'h0000;
    $display("test_sbr done");
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("BAD watchdog expected done seen hang");
    finish_test;
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset;
    test_pin;
    test_pwren;
    test_pwrgood;
    test_hotrst;
    test_sbr;
    finish_test;
  end
endmodule // dprs_sequencer_bench

bind dprs_sequencer dprs_sequencer_monitor mon_u (.ref_clk(ref_clk),
  .rst(rst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .linkUp(linkUp), .portPowerGoodInN(portPowerGoodInN),
  .tsHotResetTx(tsHotResetTx), .discardQueued(discardQueued),
  .urSecondary(urSecondary), .portResetOutN(portResetOutN),
  .portResetOutOeN(portResetOutOeN),
  .portPowerEnableOut(portPowerEnableOut));
